// [icerr_regs.svh]
`ifndef ICERR_REGS_SVH
`define ICERR_REGS_SVH
`define ICERR_OFS_PORT_ERR_HI 2'h0
`define ICERR_OFS_PORT_ERR_LO 2'h1
`define ICERR_OFS_ERR_CODE    2'h2
`define ICERR_OFS_ADD_CODE    2'h3
`define ICERR_PDU_LEN         3'h4
`define ICERR_PE_NONE         16'h0000
`define ICERR_PE_CONFLICT     16'h7000
`define ICERR_PE_INCORRECT    16'h7001
`define ICERR_PE_BLOCKED      16'h7002
`define ICERR_PE_TIMEOUT      16'h8000
`define ICERR_PE_BAD_PORT     16'h8001
`define ICERR_PE_RD_FAULT     16'h8052
`define ICERR_PE_WR_FAULT     16'h8053
`define ICERR_PE_FN_FAILED    16'h8055
`define ICERR_PE_FN_NOT_AVAIL 16'h8056
`define ICERR_PE_FN_NOT_SUPP  16'h8057
`endif

// [icerr_pkg.sv]
package icerr_pkg;
  typedef enum logic [1:0] {
    ICERR_ST_IDLE,
    ICERR_ST_SEND
  } icerr_state_e;
endpackage

// [icerr_classify.sv]
`include "icerr_regs.svh"
module icerr_classify (
  input  wire logic        hdr_conflict_in,
  input  wire logic        hdr_mismatch_in,
  input  wire logic        port_blocked_in,
  input  wire logic        bad_port_in,
  input  wire logic        fn_not_supp_in,
  input  wire logic        fn_not_avail_in,
  input  wire logic        fn_failed_in,
  input  wire logic        service_fail_in,
  output logic      [15:0] port_err_out
);
  // Header faults first: nothing else is trustworthy without a sane header
  always_comb begin
    if (hdr_conflict_in) begin
      port_err_out = `ICERR_PE_CONFLICT; // see R03
    end else if (hdr_mismatch_in) begin
      port_err_out = `ICERR_PE_INCORRECT; // see R03
    end else if (bad_port_in) begin
      port_err_out = `ICERR_PE_BAD_PORT;
    end else if (port_blocked_in) begin
      port_err_out = `ICERR_PE_BLOCKED; // see R04
    end else if (fn_not_supp_in) begin
      port_err_out = `ICERR_PE_FN_NOT_SUPP; // see R09
    end else if (fn_not_avail_in) begin
      port_err_out = `ICERR_PE_FN_NOT_AVAIL; // see R08
    end else if (fn_failed_in || service_fail_in) begin
      port_err_out = `ICERR_PE_FN_FAILED;
    end else begin
      port_err_out = `ICERR_PE_NONE; // see R10
    end
  end
endmodule

// [icerr_pdu.sv]
`include "icerr_regs.svh"
// Function
// R01 - Port error at byte 0, error code at byte 2, additional code at byte 3.
// R02 - The two code bytes carry the codes returned by the underlying service.
// R03 - Header inconsistency gives 0x7000, request/response mismatch 0x7001.
// R04 - A temporarily unavailable port gives 0x7002.
// R05 - The client flags 0x8000 when a call never terminates (busy timeout).
// R06 - The client flags 0x8052 when its record read invocation fails.
// R07 - The client flags 0x8053 when its record write invocation fails.
// R08 - A function not possible in the port's present state gives 0x8056.
// R09 - A function unsupported on the addressed port gives 0x8057.
// R10 - Zero means success and no reserved value is ever produced.
module icerr_pdu (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       call_done_in,
  input  wire logic       hdr_conflict_in,
  input  wire logic       hdr_mismatch_in,
  input  wire logic       port_blocked_in,
  input  wire logic       bad_port_in,
  input  wire logic       fn_not_supp_in,
  input  wire logic       fn_not_avail_in,
  input  wire logic       fn_failed_in,
  input  wire logic       service_fail_in,
  input  wire logic [7:0] al_err_code_in,
  input  wire logic [7:0] al_add_code_in,
  input  wire logic       byte_ready_in,
  output logic            ok_out,
  output logic            done_out,
  output logic            byte_valid_out,
  output logic      [7:0] byte_out,
  output logic      [1:0] byte_ofs_out,
  output logic            byte_last_out,
  output logic      [15:0] port_err_out
);

  icerr_pkg::icerr_state_e state;
  icerr_pkg::icerr_state_e next_state;
  logic [1:0]              idx;
  logic [1:0]              next_idx;

  logic [15:0]             code;
  logic [15:0]             next_port_err;
  logic [7:0]              pdu [0:3];
  logic [7:0]              next_pdu [0:3];
  logic [7:0]              load_pdu [0:3];

  logic                    take;
  logic                    take_ok;
  logic                    take_err;
  logic                    advance;
  logic                    last_taken;
  logic                    next_ok;
  logic                    next_done;

  logic                    next_byte_valid;
  logic [7:0]              next_byte;
  logic [1:0]              next_byte_ofs;
  logic                    next_byte_last;

  icerr_classify u_classify (
    .hdr_conflict_in (hdr_conflict_in),
    .hdr_mismatch_in (hdr_mismatch_in),
    .port_blocked_in (port_blocked_in),
    .bad_port_in     (bad_port_in),
    .fn_not_supp_in  (fn_not_supp_in),
    .fn_not_avail_in (fn_not_avail_in),
    .fn_failed_in    (fn_failed_in),
    .service_fail_in (service_fail_in),
    .port_err_out    (code)
  );

  // A call is taken only while idle; one landing mid-stream is dropped
  always_comb begin
    take     = (state == icerr_pkg::ICERR_ST_IDLE) && call_done_in;
    take_ok  = take && (code == `ICERR_PE_NONE); // see R10
    take_err = take && (code != `ICERR_PE_NONE);
  end

  // A stalled sink holds the byte; no timeout here, the caller owns that
  always_comb begin
    advance    = (state == icerr_pkg::ICERR_ST_SEND) && byte_ready_in;
    last_taken = advance && (idx == 2'h3);
  end

  // Port error goes out big-endian, high byte first as on the wire
  always_comb begin
    load_pdu[`ICERR_OFS_PORT_ERR_HI] = code[15:8]; // see R01
    load_pdu[`ICERR_OFS_PORT_ERR_LO] = code[7:0]; // see R01
    load_pdu[`ICERR_OFS_ERR_CODE]    = al_err_code_in; // see R02
    load_pdu[`ICERR_OFS_ADD_CODE]    = al_add_code_in; // see R02
  end

  // Only an error call loads the bytes; a success leaves the last response
  for (genvar g = 0; g < 4; g++) begin : g_pdu
    always_comb begin
      next_pdu[g] = take_err ? load_pdu[g] : pdu[g];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pdu[g] <= 8'h00;
      end else begin
        pdu[g] <= next_pdu[g];
      end
    end
  end

  // Two states suffice: the classifier settles the code in the call cycle
  always_comb begin
    next_state = state;
    unique case (state)
      icerr_pkg::ICERR_ST_IDLE: begin
        if (take_err) begin
          next_state = icerr_pkg::ICERR_ST_SEND;
        end
      end
      icerr_pkg::ICERR_ST_SEND: begin
        if (last_taken) begin
          next_state = icerr_pkg::ICERR_ST_IDLE;
        end
      end
      default: begin
        next_state = icerr_pkg::ICERR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= icerr_pkg::ICERR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Offset restarts at zero for every response
  always_comb begin
    next_idx = idx;
    unique case (state)
      icerr_pkg::ICERR_ST_IDLE: begin
        if (take_err) begin
          next_idx = 2'h0;
        end
      end
      icerr_pkg::ICERR_ST_SEND: begin
        if (advance && !last_taken) begin
          next_idx = idx + 2'h1;
        end
      end
      default: begin
        next_idx = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx <= 2'h0;
    end else begin
      idx <= next_idx;
    end
  end

  // Done ends either outcome so the caller waits on one strobe only
  always_comb begin
    next_ok   = take_ok; // see R10
    next_done = take_ok || last_taken;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ok_out   <= 1'b0;
      done_out <= 1'b0;
    end else begin
      ok_out   <= next_ok;
      done_out <= next_done;
    end
  end

  // Held until the next taken call so the caller may read it late
  always_comb begin
    if (take) begin
      next_port_err = code;
    end else begin
      next_port_err = port_err_out;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_err_out <= `ICERR_PE_NONE;
    end else begin
      port_err_out <= next_port_err;
    end
  end

  // Stream outputs come from next values so they leave flops in step
  // with the state instead of one cycle behind it
  always_comb begin
    next_byte_valid = (next_state == icerr_pkg::ICERR_ST_SEND);
    next_byte       = next_pdu[next_idx];
    next_byte_ofs   = next_idx;
    next_byte_last  = next_byte_valid && (next_idx == 2'h3);
  end

  // Reset values are the idle levels so no false byte follows reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_valid_out <= 1'b0;
      byte_out       <= 8'h00;
      byte_ofs_out   <= 2'h0;
      byte_last_out  <= 1'b0;
    end else begin
      byte_valid_out <= next_byte_valid;
      byte_out       <= next_byte;
      byte_ofs_out   <= next_byte_ofs;
      byte_last_out  <= next_byte_last;
    end
  end
endmodule

// [icerr_monitor.sv]
module icerr_monitor (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        call_done_in,
  input wire logic        hdr_conflict_in,
  input wire logic        byte_ready_in,
  input wire logic        ok_out,
  input wire logic        done_out,
  input wire logic        byte_valid_out,
  input wire logic [7:0]  byte_out,
  input wire logic [1:0]  byte_ofs_out,
  input wire logic        byte_last_out,
  input wire logic [15:0] port_err_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_take;
    call_done_in && !byte_valid_out && hdr_conflict_in;
  endsequence
  sequence s_first;
    byte_valid_out && byte_ofs_out == 2'h0 && port_err_out == 16'h7000;
  endsequence
  a_conflict_code: assert property (s_take |=> s_first)
    else $error("conflict call gave wrong first byte");
  a_ok_zero: assert property (
    ok_out |-> done_out && port_err_out == 16'h0000)
    else $error("success with nonzero port error");
  a_byte_hold: assert property (byte_valid_out && !byte_ready_in |=>
    byte_valid_out && $stable(byte_out) && $stable(byte_ofs_out))
    else $error("byte changed while stalled");
  a_ofs_step: assert property (
    byte_valid_out && byte_ready_in && !byte_last_out
    |=> byte_ofs_out == $past(byte_ofs_out) + 2'h1)
    else $error("offset did not advance by one");
  a_last_flag: assert property (byte_valid_out |->
    byte_last_out == (byte_ofs_out == 2'h3))
    else $error("last flag not tied to offset 3");
  a_end_done: assert property (
    byte_valid_out && byte_ready_in && byte_last_out
    |=> done_out && !byte_valid_out)
    else $error("no done after last byte");
  a_hi_first: assert property (
    byte_valid_out && byte_ofs_out == 2'h0 |-> byte_out == port_err_out[15:8])
    else $error("offset 0 not high byte");
  a_no_reserved: assert property (
    port_err_out inside {16'h0000, 16'h7000, 16'h7001, 16'h7002,
                         16'h8001, 16'h8055, 16'h8056, 16'h8057})
    else $error("reserved port error produced");
endmodule
bind icerr_pdu icerr_monitor mon (
  .clk_in          (clk_in),
  .rst_n_in        (rst_n_in),
  .call_done_in    (call_done_in),
  .hdr_conflict_in (hdr_conflict_in),
  .byte_ready_in   (byte_ready_in),
  .ok_out          (ok_out),
  .done_out        (done_out),
  .byte_valid_out  (byte_valid_out),
  .byte_out        (byte_out),
  .byte_ofs_out    (byte_ofs_out),
  .byte_last_out   (byte_last_out),
  .port_err_out    (port_err_out)
);

// [icerr_sink.sv]
`include "icerr_regs.svh"
module icerr_sink (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        busy_in,
  input  wire logic        rd_fail_in,
  input  wire logic        wr_fail_in,
  output logic             ready_out,
  output logic      [15:0] client_err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  int   busy_cnt = 0;
  // Slow mode stalls every other cycle to exercise hold
  always @(posedge clk_in) begin
    tog      <= !tog;
    busy_cnt <= busy_in ? busy_cnt + 1 : 0;
  end
  assign ready_out = !slow_in || tog;
  // Client-side codes; a response busy far too long counts as a timeout
  always_comb begin
    if (busy_cnt > 32) begin
      client_err_out = `ICERR_PE_TIMEOUT;
    end else if (rd_fail_in) begin
      client_err_out = `ICERR_PE_RD_FAULT;
    end else if (wr_fail_in) begin
      client_err_out = `ICERR_PE_WR_FAULT;
    end else begin
      client_err_out = `ICERR_PE_NONE;
    end
  end
endmodule

// [testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rst_n_in = 1'b0, call_done_in = 1'b0, slow = 1'b0;
  logic rd_fail = 1'b0, wr_fail = 1'b0;
  logic [15:0] client_err;
  logic hdr_conflict_in, hdr_mismatch_in, bad_port_in, port_blocked_in;
  logic fn_not_supp_in, fn_not_avail_in, fn_failed_in, service_fail_in;
  logic [7:0] al_err_code_in = 8'h0, al_add_code_in = 8'h0, byte_out;
  logic byte_ready_in, ok_out, done_out, byte_valid_out, byte_last_out;
  logic [1:0] byte_ofs_out;
  logic [15:0] port_err_out;
  int fail_count = 0, total_checks = 0;
  logic [15:0] pe_tab [8] = '{16'h7000, 16'h7001, 16'h8001, 16'h7002,
                              16'h8057, 16'h8056, 16'h8055, 16'h8055};
  logic [7:0] fl = 8'h00;
  icerr_pdu dut (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .call_done_in    (call_done_in),
    .hdr_conflict_in (hdr_conflict_in),
    .hdr_mismatch_in (hdr_mismatch_in),
    .port_blocked_in (port_blocked_in),
    .bad_port_in     (bad_port_in),
    .fn_not_supp_in  (fn_not_supp_in),
    .fn_not_avail_in (fn_not_avail_in),
    .fn_failed_in    (fn_failed_in),
    .service_fail_in (service_fail_in),
    .al_err_code_in  (al_err_code_in),
    .al_add_code_in  (al_add_code_in),
    .byte_ready_in   (byte_ready_in),
    .ok_out          (ok_out),
    .done_out        (done_out),
    .byte_valid_out  (byte_valid_out),
    .byte_out        (byte_out),
    .byte_ofs_out    (byte_ofs_out),
    .byte_last_out   (byte_last_out),
    .port_err_out    (port_err_out)
  );
  icerr_sink sink (
    .clk_in         (clk_in),
    .slow_in        (slow),
    .busy_in        (byte_valid_out),
    .rd_fail_in     (rd_fail),
    .wr_fail_in     (wr_fail),
    .ready_out      (byte_ready_in),
    .client_err_out (client_err)
  );
  always #50 clk_in = !clk_in;
  assign {hdr_conflict_in, hdr_mismatch_in, bad_port_in, port_blocked_in,
          fn_not_supp_in, fn_not_avail_in, fn_failed_in, service_fail_in} = fl;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic call(logic [7:0] f, logic [15:0] pe);
    logic [7:0] b [4];
    int n = 0;
    @(posedge clk_in);
    fl <= f;
    al_err_code_in <= f ^ 8'h5a;
    al_add_code_in <= ~f;
    call_done_in <= 1;
    @(posedge clk_in);
    fl <= 0;
    call_done_in <= 0;
    #1;
    chk("port_err", pe, port_err_out);
    chk("ok", {15'h0, pe == 0}, {15'h0, ok_out});
    if (pe != 0) begin
      for (int k = 0; k < 40 && n < 4; k++) begin
        if (byte_valid_out === 1'b1 && byte_ready_in === 1'b1) begin
          b[byte_ofs_out] = byte_out;
          n++;
        end
        @(posedge clk_in);
        #1;
      end
      chk("bytes", 16'h0004, n[15:0]);
      chk("pe_bytes", pe, {b[0], b[1]});
      chk("codes", {f ^ 8'h5a, ~f}, {b[2], b[3]});
    end
    chk("done", 16'h1, {15'h0, done_out});
    chk("client_err", 16'h0000, client_err);
  endtask
  task automatic t_client;
    rd_fail <= 1'b1;
    #1;
    chk("client_rd", 16'h8052, client_err);
    rd_fail <= 1'b0;
    wr_fail <= 1'b1;
    #1;
    chk("client_wr", 16'h8053, client_err);
    wr_fail <= 1'b0;
    #1;
    chk("client_idle", 16'h0000, client_err);
  endtask
  task automatic t_success;
    call(8'h0, 16'h0);
    call(8'h0, 16'h0);
  endtask
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      slow = i[0];
      call(8'h80 >> i, pe_tab[i]);
    end
  endtask
  task automatic t_priority;
    call(8'hff, 16'h7000);
    call(8'h0f, 16'h8057);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1;
    t_success;
    t_codes;
    t_priority;
    t_client;
    finish_test;
  end
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
endmodule
